// file: fbm_pkg.sv
// fbm_pkg: shared constants and types of the flag-branch and move unit
package fbm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // operations handed over by the instruction decoder
    typedef enum logic [4:0] {
        OP_NONE,
        OP_BRANCH_ON_EQUAL,
        OP_BRANCH_ON_NOT_EQUAL,
        OP_BRANCH_CARRY_SET,
        OP_BRANCH_UNSIGNED_LOWER,
        OP_BRANCH_CARRY_CLEAR,
        OP_BRANCH_SAME_OR_HIGHER,
        OP_BRANCH_ON_MINUS,
        OP_BRANCH_ON_PLUS,
        OP_BRANCH_SIGNED_GE,
        OP_BRANCH_SIGNED_LT,
        OP_BRANCH_HALF_CARRY_SET,
        OP_BRANCH_HALF_CARRY_CLEAR,
        OP_BRANCH_TRANSFER_BIT_SET,
        OP_BRANCH_TRANSFER_BIT_CLEAR,
        OP_BRANCH_OVERFLOW_SET,
        OP_BRANCH_OVERFLOW_CLEAR,
        OP_BRANCH_IRQ_ENABLED,
        OP_BRANCH_IRQ_DISABLED,
        OP_BYTE_MOVE,
        OP_WORD_PAIR_COPY
    } fbm_op_e;

    ////////////////////////////////////////////////////////////////////////
    // status flag positions
    localparam int FLG_CARRY      = 0;
    localparam int FLG_ZERO       = 1;
    localparam int FLG_NEGATIVE   = 2;
    localparam int FLG_OVERFLOW   = 3;
    localparam int FLG_SIGN       = 4;
    localparam int FLG_HALF_CARRY = 5;
    localparam int FLG_TRANSFER   = 6;
    localparam int FLG_IRQ_ENABLE = 7;
    localparam int SREG_W         = 8;
    localparam int REG_DATA_W     = 8;
    localparam int REG_IDX_W      = 5;

    ////////////////////////////////////////////////////////////////////////
    // register bus map
    localparam int          AXI_ADDR_W     = 8;
    localparam int          AXI_DATA_W     = 32;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_TAKEN     = 8'h08;
    localparam logic [7:0]  ADDR_NOT_TAKEN = 8'h0C;
    localparam logic [7:0]  ADDR_MOVES     = 8'h10;
    localparam int          CTRL_ENABLE    = 0;
    localparam int          CTRL_CLEAR     = 1;
    localparam logic        CTRL_ENABLE_RST = 1'b1;
    localparam int          STAT_BUSY      = 0;
    localparam int          STAT_LAST_TKN  = 1;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    localparam int          CNT_W          = 32;

endpackage : fbm_pkg

// file: fbm_cond.sv
// fbm_cond: branch condition evaluation from the status flags
`timescale 1ns/1ps
module fbm_cond
    import fbm_pkg::*;
(
    input  wire fbm_pkg::fbm_op_e       i_op,
    input  wire logic [SREG_W-1:0]      i_sreg,
    output logic                        o_is_branch,
    output logic                        o_taken
);
    wire z  = i_sreg[FLG_ZERO];
    wire c  = i_sreg[FLG_CARRY];
    wire n  = i_sreg[FLG_NEGATIVE];
    wire v  = i_sreg[FLG_OVERFLOW];
    wire h  = i_sreg[FLG_HALF_CARRY];
    wire t  = i_sreg[FLG_TRANSFER];
    wire ie = i_sreg[FLG_IRQ_ENABLE];
    wire nv = n ^ v;

    always_comb
    begin
        o_is_branch = 1'b1;
        o_taken     = 1'b0;
        case (i_op)
            OP_BRANCH_ON_EQUAL:           o_taken = z;
            OP_BRANCH_ON_NOT_EQUAL:       o_taken = !z;
            OP_BRANCH_CARRY_SET,
            OP_BRANCH_UNSIGNED_LOWER:     o_taken = c;
            OP_BRANCH_CARRY_CLEAR,
            OP_BRANCH_SAME_OR_HIGHER:     o_taken = !c;
            OP_BRANCH_ON_MINUS:           o_taken = n;
            OP_BRANCH_ON_PLUS:            o_taken = !n;
            OP_BRANCH_SIGNED_GE:          o_taken = !nv;
            OP_BRANCH_SIGNED_LT:          o_taken = nv;
            OP_BRANCH_HALF_CARRY_SET:     o_taken = h;
            OP_BRANCH_HALF_CARRY_CLEAR:   o_taken = !h;
            OP_BRANCH_TRANSFER_BIT_SET:   o_taken = t;
            OP_BRANCH_TRANSFER_BIT_CLEAR: o_taken = !t;
            OP_BRANCH_OVERFLOW_SET:       o_taken = v;
            OP_BRANCH_OVERFLOW_CLEAR:     o_taken = !v;
            OP_BRANCH_IRQ_ENABLED:        o_taken = ie;
            OP_BRANCH_IRQ_DISABLED:       o_taken = !ie;
            default:                      o_is_branch = 1'b0;
        endcase
    end
endmodule : fbm_cond

// file: fbm_cnt.sv
// fbm_cnt: event counter with synchronous clear, an increment in the clearing cycle loads one
`timescale 1ns/1ps
module fbm_cnt #(
    parameter int W = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_clr,
    input  wire logic         i_inc,
    output logic [W-1:0]      o_count
);
    localparam logic [W-1:0] ONE = W'(1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    generate
        if (W < 1)
        begin : g_chk
            $error("fbm_cnt: width must be at least one");
        end
    endgenerate

    // an event in the clearing cycle still counts
    assign cnt_d = i_clr ? (i_inc ? ONE : '0) : (i_inc ? cnt_q + ONE : cnt_q);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    assign o_count = cnt_q;
endmodule : fbm_cnt

// file: fbm_exec.sv
// fbm_exec: conditional relative branches and register moves of the core
`timescale 1ns/1ps
module fbm_exec
    import fbm_pkg::*;
#(
    parameter int PC_W   = 16,
    parameter int OFFS_W = 7
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    // issue from the instruction decoder
    input  wire logic                          i_issue_valid,
    output logic                               o_issue_ready,
    input  wire fbm_pkg::fbm_op_e              i_op,
    input  wire logic [OFFS_W-1:0]             i_offset,
    input  wire logic [PC_W-1:0]               i_pc,
    input  wire logic [fbm_pkg::SREG_W-1:0]    i_sreg,
    input  wire logic [fbm_pkg::REG_IDX_W-1:0] i_dst_idx,
    input  wire logic [fbm_pkg::REG_DATA_W-1:0] i_src_lo,
    input  wire logic [fbm_pkg::REG_DATA_W-1:0] i_src_hi,
    // completion toward program counter, flags and register file
    output logic                               o_done,
    output logic [PC_W-1:0]                    o_pc_next,
    output logic                               o_sreg_we,
    output logic                               o_wr_lo_en,
    output logic [fbm_pkg::REG_IDX_W-1:0]      o_wr_lo_idx,
    output logic [fbm_pkg::REG_DATA_W-1:0]     o_wr_lo_data,
    output logic                               o_wr_hi_en,
    output logic [fbm_pkg::REG_IDX_W-1:0]      o_wr_hi_idx,
    output logic [fbm_pkg::REG_DATA_W-1:0]     o_wr_hi_data,
    // axi4-lite slave
    input  wire logic                          i_awvalid,
    output logic                               o_awready,
    input  wire logic [fbm_pkg::AXI_ADDR_W-1:0] i_awaddr,
    input  wire logic                          i_wvalid,
    output logic                               o_wready,
    input  wire logic [fbm_pkg::AXI_DATA_W-1:0] i_wdata,
    input  wire logic [3:0]                    i_wstrb,
    output logic                               o_bvalid,
    input  wire logic                          i_bready,
    output logic [1:0]                         o_bresp,
    input  wire logic                          i_arvalid,
    output logic                               o_arready,
    input  wire logic [fbm_pkg::AXI_ADDR_W-1:0] i_araddr,
    output logic                               o_rvalid,
    input  wire logic                          i_rready,
    output logic [fbm_pkg::AXI_DATA_W-1:0]     o_rdata,
    output logic [1:0]                         o_rresp
);
    import fbm_pkg::*;

    typedef enum logic {
        ST_IDLE,
        ST_TAKEN
    } fbm_state_e;

    localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);

    generate
        if (OFFS_W < 2 || PC_W < OFFS_W || PC_W > AXI_DATA_W)
        begin : g_chk
            $error("fbm_exec: offset and pc widths out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // declarations
    fbm_state_e                 state_q;
    fbm_state_e                 state_d;
    logic [PC_W-1:0]            target_q;
    logic [PC_W-1:0]            pc_next_q;
    logic                       done_q;
    logic                       last_taken_q;
    logic                       wr_lo_en_q;
    logic [REG_IDX_W-1:0]       wr_lo_idx_q;
    logic [REG_DATA_W-1:0]      wr_lo_data_q;
    logic                       wr_hi_en_q;
    logic [REG_IDX_W-1:0]       wr_hi_idx_q;
    logic [REG_DATA_W-1:0]      wr_hi_data_q;
    logic                       enable_q;
    logic                       clear_q;
    logic                       aw_have_q;
    logic [AXI_ADDR_W-1:0]      aw_addr_q;
    logic                       w_have_q;
    logic [AXI_DATA_W-1:0]      w_data_q;
    logic [3:0]                 w_strb_q;
    logic                       bvalid_q;
    logic [1:0]                 bresp_q;
    logic                       rvalid_q;
    logic [AXI_DATA_W-1:0]      rdata_q;
    logic [1:0]                 rresp_q;
    logic [CNT_W-1:0]           cnt_taken;
    logic [CNT_W-1:0]           cnt_not_taken;
    logic [CNT_W-1:0]           cnt_moves;

    ////////////////////////////////////////////////////////////////////////
    // issue decode
    wire                is_branch;
    wire                taken;
    wire                accept      = i_issue_valid && o_issue_ready;
    wire                is_byte_mv  = (i_op == OP_BYTE_MOVE);
    wire                is_pair_cp  = (i_op == OP_WORD_PAIR_COPY);
    wire                is_move     = is_byte_mv || is_pair_cp;
    wire                br_taken    = accept && is_branch && taken;
    wire                br_skip     = accept && is_branch && !taken;
    wire                mv_go       = accept && is_move;
    wire [PC_W-1:0]     off_ext     = {{(PC_W-OFFS_W){i_offset[OFFS_W-1]}},
                                       i_offset};
    wire [PC_W-1:0]     pc_seq      = i_pc + PC_ONE;
    wire [PC_W-1:0]     pc_target   = i_pc + off_ext + PC_ONE;
    wire [REG_IDX_W-1:0] pair_lo    = {i_dst_idx[REG_IDX_W-1:1], 1'b0};
    wire [REG_IDX_W-1:0] pair_hi    = {i_dst_idx[REG_IDX_W-1:1], 1'b1};

    fbm_cond u_cond (
        .i_op        (i_op),
        .i_sreg      (i_sreg),
        .o_is_branch (is_branch),
        .o_taken     (taken)
    );

    // a taken branch holds off the next issue for one extra clock
    assign o_issue_ready = (state_q == ST_IDLE) && enable_q;

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (br_taken)
                    state_d = ST_TAKEN;
            end
            ST_TAKEN:
            begin
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    wire            done_d    = br_skip || mv_go || (state_q == ST_TAKEN);
    wire [PC_W-1:0] pc_next_d = (state_q == ST_TAKEN) ? target_q : pc_seq;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q      <= ST_IDLE;
            target_q     <= '0;
            done_q       <= 1'b0;
            pc_next_q    <= '0;
            last_taken_q <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            done_q   <= done_d;
            if (br_taken)
                target_q <= pc_target;
            if (done_d)
                pc_next_q <= pc_next_d;
            if (accept && is_branch)
                last_taken_q <= taken;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file writes
    wire [REG_DATA_W-1:0] lo_data_d = i_src_lo;
    wire [REG_IDX_W-1:0]  lo_idx_d  = is_pair_cp ? pair_lo : i_dst_idx;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_lo_en_q   <= 1'b0;
            wr_lo_idx_q  <= '0;
            wr_lo_data_q <= '0;
            wr_hi_en_q   <= 1'b0;
            wr_hi_idx_q  <= '0;
            wr_hi_data_q <= '0;
        end
        else
        begin
            wr_lo_en_q <= mv_go;
            wr_hi_en_q <= accept && is_pair_cp;
            if (mv_go)
            begin
                wr_lo_idx_q  <= lo_idx_d;
                wr_lo_data_q <= lo_data_d;
                wr_hi_idx_q  <= pair_hi;
                wr_hi_data_q <= i_src_hi;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // activity counters
    fbm_cnt #(.W(CNT_W)) u_cnt_taken (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_clr   (clear_q),
        .i_inc   (br_taken),
        .o_count (cnt_taken)
    );

    fbm_cnt #(.W(CNT_W)) u_cnt_not_taken (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_clr   (clear_q),
        .i_inc   (br_skip),
        .o_count (cnt_not_taken)
    );

    fbm_cnt #(.W(CNT_W)) u_cnt_moves (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_clr   (clear_q),
        .i_inc   (mv_go),
        .o_count (cnt_moves)
    );

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write path
    wire aw_take  = i_awvalid && o_awready;
    wire w_take   = i_wvalid && o_wready;
    wire wr_fire  = aw_have_q && w_have_q && !bvalid_q;
    wire wr_ctrl  = (aw_addr_q[AXI_ADDR_W-1:2] == ADDR_CTRL[AXI_ADDR_W-1:2]);
    wire wr_ro    = (aw_addr_q[AXI_ADDR_W-1:2] == ADDR_STATUS[AXI_ADDR_W-1:2])
                 || (aw_addr_q[AXI_ADDR_W-1:2] == ADDR_TAKEN[AXI_ADDR_W-1:2])
                 || (aw_addr_q[AXI_ADDR_W-1:2]
                     == ADDR_NOT_TAKEN[AXI_ADDR_W-1:2])
                 || (aw_addr_q[AXI_ADDR_W-1:2] == ADDR_MOVES[AXI_ADDR_W-1:2]);
    wire ctrl_we  = wr_fire && wr_ctrl && w_strb_q[0];
    wire [1:0] wresp_d = (wr_ctrl || wr_ro) ? RESP_OKAY : RESP_SLVERR;

    assign o_awready = !aw_have_q && !bvalid_q;
    assign o_wready  = !w_have_q && !bvalid_q;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q  <= 1'b0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= i_awaddr;
            end
            if (w_take)
            begin
                w_have_q <= 1'b1;
                w_data_q <= i_wdata;
                w_strb_q <= i_wstrb;
            end
            if (wr_fire)
            begin
                bvalid_q  <= 1'b1;
                bresp_q   <= wresp_d;
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end
            else if (bvalid_q && i_bready)
                bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            enable_q <= CTRL_ENABLE_RST;
            clear_q  <= 1'b0;
        end
        else
        begin
            clear_q <= ctrl_we && w_data_q[CTRL_CLEAR];
            if (ctrl_we)
                enable_q <= w_data_q[CTRL_ENABLE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read path
    wire [AXI_ADDR_W-3:0] ra = i_araddr[AXI_ADDR_W-1:2];
    wire ar_take  = i_arvalid && o_arready;
    wire rd_ctrl  = (ra == ADDR_CTRL[AXI_ADDR_W-1:2]);
    wire rd_stat  = (ra == ADDR_STATUS[AXI_ADDR_W-1:2]);
    wire rd_tkn   = (ra == ADDR_TAKEN[AXI_ADDR_W-1:2]);
    wire rd_ntkn  = (ra == ADDR_NOT_TAKEN[AXI_ADDR_W-1:2]);
    wire rd_mov   = (ra == ADDR_MOVES[AXI_ADDR_W-1:2]);
    wire rd_hit   = rd_ctrl || rd_stat || rd_tkn || rd_ntkn || rd_mov;
    wire [AXI_DATA_W-1:0] ctrl_word = AXI_DATA_W'(enable_q) << CTRL_ENABLE;
    wire [AXI_DATA_W-1:0] stat_word =
        (AXI_DATA_W'(state_q == ST_TAKEN) << STAT_BUSY)
        | (AXI_DATA_W'(last_taken_q) << STAT_LAST_TKN);
    wire [AXI_DATA_W-1:0] rdata_d =
          rd_ctrl ? ctrl_word
        : rd_stat ? stat_word
        : rd_tkn  ? cnt_taken
        : rd_ntkn ? cnt_not_taken
        : rd_mov  ? cnt_moves
        : '0;

    assign o_arready = !rvalid_q;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= rdata_d;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_q && i_rready)
            rvalid_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_done       = done_q;
    assign o_pc_next    = pc_next_q;
    assign o_sreg_we    = 1'b0;
    assign o_wr_lo_en   = wr_lo_en_q;
    assign o_wr_lo_idx  = wr_lo_idx_q;
    assign o_wr_lo_data = wr_lo_data_q;
    assign o_wr_hi_en   = wr_hi_en_q;
    assign o_wr_hi_idx  = wr_hi_idx_q;
    assign o_wr_hi_data = wr_hi_data_q;
    assign o_bvalid     = bvalid_q;
    assign o_bresp      = bresp_q;
    assign o_rvalid     = rvalid_q;
    assign o_rdata      = rdata_q;
    assign o_rresp      = rresp_q;
endmodule : fbm_exec

// file: fbm_exec_chk.sv
// fbm_exec_chk: port-level checks of the branch and move unit
`timescale 1ns/1ps
module fbm_exec_chk
    import fbm_pkg::*;
#(
    parameter int PC_W   = 16,
    parameter int OFFS_W = 7
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_issue_valid,
    input  wire logic              o_issue_ready,
    input  wire fbm_pkg::fbm_op_e  i_op,
    input  wire logic [OFFS_W-1:0] i_offset,
    input  wire logic [PC_W-1:0]   i_pc,
    input  wire logic [7:0]        i_sreg,
    input  wire logic [4:0]        i_dst_idx,
    input  wire logic [7:0]        i_src_lo,
    input  wire logic [7:0]        i_src_hi,
    input  wire logic              o_done,
    input  wire logic [PC_W-1:0]   o_pc_next,
    input  wire logic              o_sreg_we,
    input  wire logic              o_wr_lo_en,
    input  wire logic [4:0]        o_wr_lo_idx,
    input  wire logic [7:0]        o_wr_lo_data,
    input  wire logic              o_wr_hi_en,
    input  wire logic [4:0]        o_wr_hi_idx,
    input  wire logic [7:0]        o_wr_hi_data
);
    wire logic            acc = i_issue_valid && o_issue_ready;
    wire logic [PC_W-1:0] nxt = i_pc + 1'b1;
    wire logic [PC_W-1:0] tgt =
        nxt + {{(PC_W-OFFS_W){i_offset[OFFS_W-1]}}, i_offset};
    wire logic            nv = i_sreg[FLG_NEGATIVE] ^ i_sreg[FLG_OVERFLOW];
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////
    flags_kept_a: assert property (!o_sreg_we)
        else $error("flag write seen");
    eq_taken_a: assert property (
        acc && i_op == OP_BRANCH_ON_EQUAL && i_sreg[FLG_ZERO] |=>
        !o_done && !o_issue_ready ##1 o_done && o_pc_next == $past(tgt, 2))
        else $error("equal branch taken wrong");
    eq_fall_a: assert property (
        acc && i_op == OP_BRANCH_ON_EQUAL && !i_sreg[FLG_ZERO] |=>
        o_done && o_pc_next == $past(nxt))
        else $error("equal branch fall wrong");
    ne_taken_a: assert property (
        acc && i_op == OP_BRANCH_ON_NOT_EQUAL && !i_sreg[FLG_ZERO] |=>
        ##1 o_done && o_pc_next == $past(tgt, 2))
        else $error("not-equal branch wrong");
    lt_taken_a: assert property (
        acc && i_op == OP_BRANCH_SIGNED_LT && nv |=>
        !o_done ##1 o_done && o_pc_next == $past(tgt, 2))
        else $error("signed lt wrong");
    ge_fall_a: assert property (
        acc && i_op == OP_BRANCH_SIGNED_GE && nv |=>
        o_done && o_pc_next == $past(nxt))
        else $error("signed ge wrong");
    hc_fall_a: assert property (
        acc && i_op == OP_BRANCH_HALF_CARRY_SET && !i_sreg[FLG_HALF_CARRY]
        |=> o_done && o_pc_next == $past(nxt))
        else $error("half carry fall wrong");
    byte_move_a: assert property (
        acc && i_op == OP_BYTE_MOVE |=> o_done && o_wr_lo_en && !o_wr_hi_en
        && o_wr_lo_data == $past(i_src_lo) && o_wr_lo_idx == $past(i_dst_idx))
        else $error("byte move wrong");
    pair_copy_a: assert property (
        acc && i_op == OP_WORD_PAIR_COPY |=> o_done && o_wr_hi_en
        && o_wr_hi_data == $past(i_src_hi)
        && o_wr_hi_idx == {$past(i_dst_idx[4:1]), 1'b1})
        else $error("pair copy wrong");
    cover property (acc && i_op == OP_BRANCH_ON_EQUAL && i_sreg[FLG_ZERO]);
    cover property (acc && i_op == OP_BYTE_MOVE);
    cover property (acc && i_op == OP_WORD_PAIR_COPY);
endmodule : fbm_exec_chk

// file: tb_flag_branch_and_move_exec.sv
// tb_flag_branch_and_move_exec: self-checking bench of the branch and move unit and its registers
`timescale 1ns/1ps
module tb_flag_branch_and_move_exec;
    import fbm_pkg::*;
    logic        i_clk, i_rst, i_issue_valid, i_awvalid, i_wvalid;
    logic        i_bready, i_arvalid, i_rready, o_issue_ready, o_done;
    logic        o_sreg_we, o_wr_lo_en, o_wr_hi_en, o_awready, o_wready;
    logic        o_bvalid, o_arready, o_rvalid;
    fbm_op_e     i_op;
    logic [6:0]  i_offset;
    logic [15:0] i_pc, o_pc_next;
    logic [7:0]  i_sreg, i_src_lo, i_src_hi, o_wr_lo_data, o_wr_hi_data;
    logic [7:0]  i_awaddr, i_araddr;
    logic [4:0]  i_dst_idx, o_wr_lo_idx, o_wr_hi_idx;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0]  i_wstrb;
    logic [1:0]  o_bresp, o_rresp;
    int          error_cnt = 0;
    int          n_tests = 0;
    fbm_exec #(.PC_W(16), .OFFS_W(7)) DUT (.*);
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic issue(input fbm_op_e op, input logic [7:0] sr,
                         input logic [15:0] pc, input logic [6:0] k,
                         output int lat);
        @(posedge i_clk);
        i_issue_valid <= 1'b1;
        i_op <= op;
        i_sreg <= sr;
        i_pc <= pc;
        i_offset <= k;
        do @(negedge i_clk); while (o_issue_ready !== 1'b1);
        @(posedge i_clk);
        i_issue_valid <= 1'b0;
        lat = 0;
        do
        begin
            @(negedge i_clk);
            lat++;
        end while (o_done !== 1'b1 && lat < 4);
    endtask : issue
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        @(posedge i_clk);
        {i_awvalid, i_wvalid, i_bready} <= 3'b111;
        i_awaddr <= a;
        i_wdata <= d;
        {aw, w} = 2'b00;
        while (!(aw && w))
        begin
            @(negedge i_clk);
            aw = aw || (i_awvalid && o_awready);
            w = w || (i_wvalid && o_wready);
            @(posedge i_clk);
            i_awvalid <= !aw;
            i_wvalid <= !w;
        end
        do @(negedge i_clk); while (o_bvalid !== 1'b1);
        chk("bresp", 32'h0000_0000, 32'(o_bresp));
        @(posedge i_clk);
        i_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] r);
        @(posedge i_clk);
        {i_arvalid, i_rready} <= 2'b11;
        i_araddr <= a;
        do @(negedge i_clk); while (o_arready !== 1'b1);
        @(posedge i_clk);
        i_arvalid <= 1'b0;
        do @(negedge i_clk); while (o_rvalid !== 1'b1);
        chk("rdata", e, o_rdata);
        chk("rresp", 32'(r), 32'(o_rresp));
        @(posedge i_clk);
        i_rready <= 1'b0;
    endtask : axi_rd
    ////////////////////////////////////////////////////////////////////////
    task automatic run_branches();
        fbm_op_e ops[20] = '{OP_BRANCH_ON_EQUAL, OP_BRANCH_ON_NOT_EQUAL,
            OP_BRANCH_CARRY_SET, OP_BRANCH_UNSIGNED_LOWER,
            OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER,
            OP_BRANCH_ON_MINUS, OP_BRANCH_ON_PLUS, OP_BRANCH_SIGNED_GE,
            OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT, OP_BRANCH_SIGNED_LT,
            OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLEAR,
            OP_BRANCH_TRANSFER_BIT_SET, OP_BRANCH_TRANSFER_BIT_CLEAR,
            OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
            OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED};
        int bits[20] = '{1, 1, 0, 0, 0, 0, 2, 2, 2, 3, 2, 3, 5, 5, 6, 6, 3,
                         3, 7, 7};
        bit pol[20] = '{1, 0, 1, 1, 0, 0, 1, 0, 0, 0, 1, 1, 1, 0, 1, 0, 1,
                        0, 1, 0};
        logic [15:0] pc, ex;
        logic [6:0]  k;
        int          lat;
        bit          tk;
        for (int i = 0; i < 20; i++)
            for (int s = 0; s < 2; s++)
            begin
                pc = 16'h0100 + 16'(i);
                k = s ? 7'h7B : 7'h3F;
                tk = (s == pol[i]);
                ex = tk ? pc + {{9{k[6]}}, k} + 16'h0001 : pc + 16'h0001;
                issue(ops[i], 8'(s) << bits[i], pc, k, lat);
                chk("cycles", tk ? 2 : 1, lat);
                chk("pc_next", 32'(ex), 32'(o_pc_next));
                chk("pc_next", 32'(ex), 32'(o_pc_next));
                chk("pc_next", 32'(ex), 32'(o_pc_next));
                chk("flag write", 0, 32'(o_sreg_we));
            end
    endtask : run_branches
    task automatic run_moves();
        int lat;
        @(posedge i_clk);
        i_src_lo <= 8'hA5;
        i_src_hi <= 8'h3C;
        i_dst_idx <= 5'h11;
        issue(OP_BYTE_MOVE, 8'hFF, 16'h0200, 7'h00, lat);
        chk("cycles", 1, lat);
        chk("lo write", {1'b1, 5'h11, 8'hA5}, {o_wr_lo_en, o_wr_lo_idx,
            o_wr_lo_data});
        chk("pc_next", 32'h0000_0201, 32'(o_pc_next));
        chk("hi write", 0, 32'(o_wr_hi_en));
        issue(OP_WORD_PAIR_COPY, 8'hFF, 16'h0201, 7'h00, lat);
        chk("cycles", 1, lat);
        chk("pair", {1'b1, 5'h10, 8'hA5, 1'b1, 5'h11, 8'h3C}, {o_wr_lo_en,
            o_wr_lo_idx, o_wr_lo_data, o_wr_hi_en, o_wr_hi_idx,
            o_wr_hi_data});
        chk("flag write", 0, 32'(o_sreg_we));
    endtask : run_moves
    task automatic run_regs();
        axi_rd(8'h08, 32'h0000_0014, 2'h0);
        axi_rd(8'h0C, 32'h0000_0014, 2'h0);
        axi_rd(8'h10, 32'h0000_0002, 2'h0);
        axi_rd(8'h14, 32'h0000_0000, 2'h2);
        axi_wr(8'h00, 32'h0000_0000);
        @(negedge i_clk);
        chk("issue ready", 0, 32'(o_issue_ready));
        axi_wr(8'h00, 32'h0000_0003);
        axi_rd(8'h08, 32'h0000_0000, 2'h0);
        axi_rd(8'h00, 32'h0000_0001, 2'h0);
    endtask : run_regs
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial
    begin
        #200_000;
        error_cnt++;
        conclude();
    end
    initial
    begin
        {i_rst, i_issue_valid, i_awvalid, i_wvalid, i_bready} = 5'h10;
        {i_arvalid, i_rready, i_offset, i_pc, i_sreg} = '0;
        i_op = OP_NONE;
        {i_src_lo, i_src_hi, i_dst_idx, i_awaddr, i_araddr, i_wdata} = '0;
        i_wstrb = 4'hF;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        axi_rd(8'h00, 32'h0000_0001, 2'h0);
        run_branches();
        run_moves();
        run_regs();
        conclude();
    end
endmodule : tb_flag_branch_and_move_exec
bind fbm_exec fbm_exec_chk #(.PC_W(PC_W), .OFFS_W(OFFS_W)) u_chk (.*);
